// [verilog/ubg_consts.svh]
// Purpose: Named constants for the serial port baud generator block.
// Assumes: Included by bare name; definitions only.
// Notes:   Register indices are word indices; byte address is four times the index.
`ifndef UBG_CONSTS_SVH
`define UBG_CONSTS_SVH

// ----------------------------------------------------------------------
// Register indices and bus geometry
// ----------------------------------------------------------------------
`define UBG_ADDR_W          12
`define UBG_IDX_W           10
`define UBG_IDX_RX_CTRL     10'h018
`define UBG_IDX_TX_CTRL     10'h098
`define UBG_IDX_BAUD_DIV    10'h099
`define UBG_BYTE_LSB        2'h0

// ----------------------------------------------------------------------
// Field positions in transmit_control_status
// ----------------------------------------------------------------------
`define UBG_TX_CLK_SRC      7
`define UBG_TX_NINE         6
`define UBG_TX_ENABLE       5
`define UBG_TX_SYNC         4
`define UBG_TX_HIGH_SPEED   2
`define UBG_TX_SHIFT_EMPTY  1
`define UBG_TX_NINTH_DATA   0
`define UBG_TX_WR_MASK      8'hF5

// ----------------------------------------------------------------------
// Field positions in receive_control_status
// ----------------------------------------------------------------------
`define UBG_RX_FRAME_ERR    2
`define UBG_RX_OVERRUN      1
`define UBG_RX_NINTH_DATA   0
`define UBG_RX_WR_MASK      8'hF8

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define UBG_TX_RESET        8'h02
`define UBG_RX_RESET        8'h00
`define UBG_DIV_RESET       8'h00

// ----------------------------------------------------------------------
// Prescale terminal counts: divide by 64, 16 and 4
// ----------------------------------------------------------------------
`define UBG_PRE_W           6
`define UBG_PRE_TOP_LOW     6'h3F
`define UBG_PRE_TOP_HIGH    6'h0F
`define UBG_PRE_TOP_SYNC    6'h03
`define UBG_PRE_ZERO        6'h00

`endif

// [verilog/ubg_pkg.sv]
// Purpose: Types shared by the baud generator block and its bench.
// Assumes: ubg_consts.svh supplies widths.
// Notes:   No import; use ubg_pkg::name.
`include "ubg_consts.svh"

package ubg_pkg;

    // APB request as seen by the slave
    typedef struct packed {
        logic                   psel;
        logic                   penable;
        logic                   pwrite;
        logic [`UBG_ADDR_W-1:0] paddr;
        logic [31:0]            pwdata;
    } ubg_apb_req_s;

    // APB answer driven by the slave
    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } ubg_apb_rsp_s;

    // Baud output toward the shift logic
    typedef struct packed {
        logic tick;
        logic syncMaster;
        logic slaveClock;
        logic highSpeed;
    } ubg_baud_s;

    // Status fed back by the shift logic, same clock
    typedef struct packed {
        logic txShiftEmpty;
        logic rxFrameErr;
        logic rxOverrun;
        logic rxNinthBit;
    } ubg_shift_stat_s;

    typedef enum logic [1:0] {
        MODE_ASYNC_LOW,
        MODE_ASYNC_HIGH,
        MODE_SYNC_MASTER,
        MODE_SYNC_SLAVE
    } ubg_mode_e;

endpackage : ubg_pkg

// [verilog/ubg_baud_gen.sv]
// Purpose: Baud rate generator with APB register access for a serial port.
// Assumes: 125 MHz clock; shift logic on the same clock feeds status bits.
// Notes:   Zero wait states beyond one registered access cycle.
`timescale 1ns/1ps
`default_nettype none
`include "ubg_consts.svh"

module ubg_baud_gen #(
    parameter int unsigned DIV_W = 8
) (
    input  wire logic                     clock,
    input  wire logic                     arst_n,
    input  wire ubg_pkg::ubg_apb_req_s    apbReq,
    output var  ubg_pkg::ubg_apb_rsp_s    apbRsp,
    input  wire ubg_pkg::ubg_shift_stat_s shiftStat,
    output var  ubg_pkg::ubg_baud_s       baudOut
);

    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    logic [7:0]       txCtrl_q;
    logic [7:0]       rxCtrl_q;
    logic [DIV_W-1:0] baudDivisor_q;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic [`UBG_IDX_W-1:0] regIdx;
    logic                  byteOk;
    logic                  hitTx;
    logic                  hitRx;
    logic                  hitDiv;
    logic                  hitAny;
    logic                  setupPhase;
    logic                  accessDone;
    logic                  wrTx;
    logic                  wrRx;
    logic                  wrDiv;

    assign regIdx     = apbReq.paddr[`UBG_ADDR_W-1:2];
    assign byteOk     = (apbReq.paddr[1:0] == `UBG_BYTE_LSB);
    assign hitTx      = byteOk && (regIdx == `UBG_IDX_TX_CTRL);
    assign hitRx      = byteOk && (regIdx == `UBG_IDX_RX_CTRL);
    assign hitDiv     = byteOk && (regIdx == `UBG_IDX_BAUD_DIV);
    assign hitAny     = hitTx || hitRx || hitDiv;
    assign setupPhase = apbReq.psel && !apbReq.penable;
    // A write lands only on the edge that completes the access
    assign accessDone = apbReq.psel && apbReq.penable && apbRsp.pready;
    assign wrTx       = accessDone && apbReq.pwrite && hitTx;
    assign wrRx       = accessDone && apbReq.pwrite && hitRx;
    assign wrDiv      = accessDone && apbReq.pwrite && hitDiv;

    // ------------------------------------------------------------------
    // Read view
    // ------------------------------------------------------------------
    logic [7:0]  txView;
    logic [7:0]  rxView;
    logic [31:0] readMux;

    always_comb begin
        txView = txCtrl_q & `UBG_TX_WR_MASK;
        txView[`UBG_TX_SHIFT_EMPTY] = shiftStat.txShiftEmpty;
        rxView = rxCtrl_q & `UBG_RX_WR_MASK;
        rxView[`UBG_RX_FRAME_ERR]  = shiftStat.rxFrameErr;
        rxView[`UBG_RX_OVERRUN]    = shiftStat.rxOverrun;
        rxView[`UBG_RX_NINTH_DATA] = shiftStat.rxNinthBit;
        readMux = 32'h0000_0000;
        if (hitTx) begin
            readMux[7:0] = txView;
        end else if (hitRx) begin
            readMux[7:0] = rxView;
        end else if (hitDiv) begin
            readMux[DIV_W-1:0] = baudDivisor_q;
        end
    end

    // ------------------------------------------------------------------
    // APB answer: captured in setup, ready in the first access cycle
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            apbRsp <= '0;
        end else begin
            apbRsp.pready <= setupPhase;
            if (setupPhase) begin
                apbRsp.prdata  <= apbReq.pwrite ? 32'h0000_0000 : readMux;
                apbRsp.pslverr <= !hitAny;
            end else if (accessDone) begin
                apbRsp.prdata  <= 32'h0000_0000;
                apbRsp.pslverr <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    // Read-only and unimplemented bits are never stored
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            txCtrl_q <= `UBG_TX_RESET & `UBG_TX_WR_MASK;
        end else if (wrTx) begin
            txCtrl_q <= apbReq.pwdata[7:0] & `UBG_TX_WR_MASK;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rxCtrl_q <= `UBG_RX_RESET;
        end else if (wrRx) begin
            rxCtrl_q <= apbReq.pwdata[7:0] & `UBG_RX_WR_MASK;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            baudDivisor_q <= DIV_W'(`UBG_DIV_RESET);
        end else if (wrDiv) begin
            baudDivisor_q <= apbReq.pwdata[DIV_W-1:0];
        end
    end

    // ------------------------------------------------------------------
    // Mode selection
    // ------------------------------------------------------------------
    ubg_pkg::ubg_mode_e       mode;
    logic [`UBG_PRE_W-1:0]    preTop;
    logic                     genRun;

    always_comb begin
        if (txCtrl_q[`UBG_TX_SYNC]) begin
            // Speed bit not consulted here
            mode = txCtrl_q[`UBG_TX_CLK_SRC] ? ubg_pkg::MODE_SYNC_MASTER
                                             : ubg_pkg::MODE_SYNC_SLAVE;
        end else begin
            mode = txCtrl_q[`UBG_TX_HIGH_SPEED] ? ubg_pkg::MODE_ASYNC_HIGH
                                                : ubg_pkg::MODE_ASYNC_LOW;
        end
    end

    always_comb begin
        genRun = 1'b1;
        unique case (mode)
            ubg_pkg::MODE_ASYNC_LOW:   preTop = `UBG_PRE_TOP_LOW;
            ubg_pkg::MODE_ASYNC_HIGH:  preTop = `UBG_PRE_TOP_HIGH;
            ubg_pkg::MODE_SYNC_MASTER: preTop = `UBG_PRE_TOP_SYNC;
            ubg_pkg::MODE_SYNC_SLAVE: begin
                // Outside clock drives the port; generator sits idle
                preTop = `UBG_PRE_TOP_SYNC;
                genRun = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Prescaler: fixed divide by 4, 16 or 64
    // ------------------------------------------------------------------
    logic [`UBG_PRE_W-1:0] preCnt_q;
    logic                  preWrap;

    // Greater-or-equal guards a mode change that lowers the top mid-count
    assign preWrap = genRun && (preCnt_q >= preTop);

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            preCnt_q <= `UBG_PRE_ZERO;
        end else if (wrDiv || !genRun || preWrap) begin
            preCnt_q <= `UBG_PRE_ZERO;
        end else begin
            preCnt_q <= preCnt_q + `UBG_PRE_W'(1);
        end
    end

    // ------------------------------------------------------------------
    // Baud timer: divisor plus one prescaled ticks per pulse
    // ------------------------------------------------------------------
    logic [DIV_W-1:0] baudCnt_q;
    logic             baudWrap;

    assign baudWrap = preWrap && (baudCnt_q >= baudDivisor_q);

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            baudCnt_q <= '0;
        end else if (wrDiv || !genRun) begin
            // New rate starts now, not after the old period
            baudCnt_q <= '0;
        end else if (baudWrap) begin
            baudCnt_q <= '0;
        end else if (preWrap) begin
            baudCnt_q <= baudCnt_q + DIV_W'(1);
        end
    end

    // ------------------------------------------------------------------
    // Outputs toward the shift logic
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            baudOut <= '0;
        end else begin
            baudOut.tick       <= baudWrap && !wrDiv;
            baudOut.syncMaster <= (mode == ubg_pkg::MODE_SYNC_MASTER);
            baudOut.slaveClock <= (mode == ubg_pkg::MODE_SYNC_SLAVE);
            baudOut.highSpeed  <= (mode == ubg_pkg::MODE_ASYNC_HIGH);
        end
    end

endmodule : ubg_baud_gen
`default_nettype wire

// [tb/ubg_baud_gen_checker.sv]
// Purpose: Port assertions for the baud generator.
// Assumes: Bound to every ubg_baud_gen instance.
// Notes:   One clock domain, so default clocking and disable.
`timescale 1ns/1ps
`default_nettype none
`include "ubg_consts.svh"
module ubg_baud_gen_checker #(
    parameter int unsigned DIV_W = 8
) (
    input wire logic                     clock,
    input wire logic                     arst_n,
    input wire ubg_pkg::ubg_apb_req_s    apbReq,
    input wire ubg_pkg::ubg_apb_rsp_s    apbRsp,
    input wire ubg_pkg::ubg_shift_stat_s shiftStat,
    input wire ubg_pkg::ubg_baud_s       baudOut
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    sequence s_setup;
        apbReq.psel && !apbReq.penable;
    endsequence
    sequence s_divWr;
        apbReq.psel && apbReq.penable && apbRsp.pready && apbReq.pwrite
            && apbReq.paddr == {`UBG_IDX_BAUD_DIV, 2'h0};
    endsequence
    property p_rdy; s_setup |=> apbRsp.pready; endproperty
    a_rdy: assert property (p_rdy) else $error("pready not one cycle after setup");
    property p_one; apbRsp.pready |=> !apbRsp.pready; endproperty
    a_one: assert property (p_one) else $error("pready longer than one cycle");
    property p_err; apbRsp.pslverr |-> apbRsp.pready; endproperty
    a_err: assert property (p_err) else $error("pslverr without pready");
    property p_wr; s_divWr |=> !baudOut.tick [*4]; endproperty
    a_wr: assert property (p_wr) else $error("tick too soon after divisor write");
    property p_gap; baudOut.tick |=> !baudOut.tick [*3]; endproperty
    a_gap: assert property (p_gap) else $error("ticks closer than four cycles");
    property p_hi; baudOut.highSpeed |-> !baudOut.syncMaster && !baudOut.slaveClock; endproperty
    a_hi: assert property (p_hi) else $error("high speed shown in sync mode");
    property p_slv; baudOut.slaveClock && $past(baudOut.slaveClock) |-> !baudOut.tick; endproperty
    a_slv: assert property (p_slv) else $error("tick in slave mode");
    property p_ms; !(baudOut.syncMaster && baudOut.slaveClock); endproperty
    a_ms: assert property (p_ms) else $error("master and slave at once");
endmodule : ubg_baud_gen_checker
bind ubg_baud_gen ubg_baud_gen_checker #(.DIV_W(DIV_W)) ubg_baud_gen_checker_inst (
    .clock(clock), .arst_n(arst_n), .apbReq(apbReq), .apbRsp(apbRsp),
    .shiftStat(shiftStat), .baudOut(baudOut));
`default_nettype wire

// [tb/ubg_shift_model.sv]
// Purpose: Shift logic stand-in: status feedback and tick spacing.
// Assumes: Same clock as the generator.
// Notes:   Period counts from the last tick, or from a mark edge.
`timescale 1ns/1ps
`default_nettype none
module ubg_shift_model (
    input  wire logic                     clock,
    input  wire logic                     arst_n,
    input  wire ubg_pkg::ubg_baud_s       baudIn,
    input  wire logic [3:0]               statSet,
    input  wire logic                     mark,
    output var  ubg_pkg::ubg_shift_stat_s shiftStat,
    output var  logic [15:0]              period,
    output var  logic                     periodValid
);
    logic [15:0] cnt_q;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) shiftStat <= '0;
        else shiftStat <= statSet;
    end
    // Mark restarts the count, so the first period shows the timer clear
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= 16'h0000;
            period <= 16'h0000;
            periodValid <= 1'b0;
        end else begin
            periodValid <= baudIn.tick;
            if (baudIn.tick) begin
                period <= cnt_q + 16'h0001;
                cnt_q <= 16'h0000;
            end else if (mark) cnt_q <= 16'h0000;
            else cnt_q <= cnt_q + 16'h0001;
        end
    end
endmodule : ubg_shift_model
`default_nettype wire

// [tb/tb_usart_baud_rate_generator.sv]
// Purpose: Self-checking bench for the baud generator.
// Assumes: APB answers with pready one cycle into access.
// Notes:   Short divisors, plus one full-scale 8'hFF, keep the run small.
`timescale 1ns/1ps
`default_nettype none
`include "ubg_consts.svh"
module tb_usart_baud_rate_generator;
    localparam logic [11:0] A_RX = {`UBG_IDX_RX_CTRL, 2'h0};
    localparam logic [11:0] A_TX = {`UBG_IDX_TX_CTRL, 2'h0};
    localparam logic [11:0] A_DIV = {`UBG_IDX_BAUD_DIV, 2'h0};
    localparam logic [7:0] MODE [4] = '{8'h00, 8'h04, 8'h90, 8'h94};
    // Expected {syncMaster, slaveClock, highSpeed} per mode
    localparam logic [2:0] MLVL [4] = '{3'h0, 3'h1, 3'h4, 3'h4};
    localparam int PRE [4] = '{64, 16, 4, 4};
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic mark = 1'b0;
    logic [3:0] statSet = 4'hC;
    logic [15:0] lfsr = 16'h054C;
    logic [15:0] period, e0, p;
    logic [15:0] extra = 16'h0000;
    logic [7:0] dv;
    logic periodValid;
    int err_total = 0;
    int num_checks = 0;
    ubg_pkg::ubg_apb_req_s req = '0;
    ubg_pkg::ubg_apb_rsp_s rsp;
    ubg_pkg::ubg_shift_stat_s stat;
    ubg_pkg::ubg_baud_s baud;
    logic [2:0] modeLvl;
    assign modeLvl = {baud.syncMaster, baud.slaveClock, baud.highSpeed};
    logic [32:0] rdQ [$];
    logic [15:0] perQ [$];
    ubg_baud_gen ubg_baud_gen_inst (.clock(clock), .arst_n(arst_n), .apbReq(req),
        .apbRsp(rsp), .shiftStat(stat), .baudOut(baud));
    ubg_shift_model ubg_shift_model_inst (.clock(clock), .arst_n(arst_n), .baudIn(baud),
        .statSet(statSet), .mark(mark), .shiftStat(stat), .period(period),
        .periodValid(periodValid));
    initial begin
        forever #4 clock = ~clock;
    end
    function automatic logic [15:0] nx(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : nx
    function automatic logic [32:0] ex(input logic [7:0] v);
        return {24'h000000, v, 1'b0};
    endfunction : ex
    task automatic cmp_rd(input logic [32:0] e, input logic [32:0] a);
        num_checks++;
        if (a !== e) begin
            err_total++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, a);
        end
    endtask : cmp_rd
    task automatic cmp_per(input logic [15:0] e, input logic [15:0] a);
        num_checks++;
        if (a !== e) begin
            err_total++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, a);
        end
    endtask : cmp_per
    task automatic cmp_mode(input logic [2:0] e, input logic [2:0] a);
        num_checks++;
        if (a !== e) begin
            err_total++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, a);
        end
    endtask : cmp_mode
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic mk, input logic [32:0] e);
        if (!w) rdQ.push_back(e);
        @(posedge clock);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clock);
        req.penable <= 1'b1;
        mark <= mk;
        // No cycle count assumed; only the watchdog ends a hung wait
        do begin
            @(posedge clock);
        end while (rsp.pready !== 1'b1);
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        mark <= 1'b0;
    endtask : apb
    task automatic print_verdict;
        if (err_total == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    always @(posedge clock) begin
        if (rsp.pready === 1'b1 && req.pwrite === 1'b0 && rdQ.size() > 0)
            cmp_rd(rdQ.pop_front(), {rsp.prdata, rsp.pslverr});
        if (periodValid === 1'b1) begin
            if (perQ.size() > 0) cmp_per(perQ.pop_front(), period);
            else extra <= extra + 16'h0001;
        end
    end
    initial begin
        #400000;
        err_total++;
        print_verdict();
    end
    initial begin
        repeat (8) @(posedge clock);
        arst_n <= 1'b1;
        apb(1'b0, A_DIV, 32'h0, 1'b0, ex(8'h00));
        apb(1'b0, A_TX, 32'h0, 1'b0, ex({6'h00, statSet[3], 1'b0}));
        for (int i = 0; i < 4; i++) begin
            lfsr = nx(lfsr);
            statSet <= lfsr[11:8];
            apb(1'b1, A_RX, {lfsr, lfsr}, 1'b0, 33'h0);
            apb(1'b0, A_RX, 32'h0, 1'b0, ex((lfsr[7:0] & `UBG_RX_WR_MASK) | statSet[2:0]));
        end
        for (int i = 0; i < 4; i++) begin
            lfsr = nx(lfsr);
            dv = (i == 2) ? 8'hFF : (i == 1) ? 8'h00 : {4'h0, lfsr[3:0]};
            apb(1'b1, A_TX, {24'h000000, MODE[i]}, 1'b0, 33'h0);
            apb(1'b0, A_TX, 32'h0, 1'b0, ex((MODE[i] & `UBG_TX_WR_MASK) | {statSet[3], 1'b0}));
            apb(1'b1, A_DIV, {24'h000000, dv}, 1'b1, 33'h0);
            // Let a tick already in flight drain before noting periods
            repeat (2) @(posedge clock);
            cmp_mode(MLVL[i], modeLvl);
            p = 16'(PRE[i] * (dv + 1));
            perQ.push_back(p + 16'h0001);
            perQ.push_back(p);
            perQ.push_back(p);
            for (int n = 0; n < 20000 && perQ.size() > 0; n++) @(posedge clock);
            // Periods still owed when the limit runs out count as a miss
            if (perQ.size() > 0) err_total++;
        end
        apb(1'b1, A_TX, 32'h00000010, 1'b0, 33'h0);
        apb(1'b1, A_DIV, 32'h00000003, 1'b1, 33'h0);
        repeat (2) @(posedge clock);
        cmp_mode(3'h2, modeLvl);
        e0 = extra;
        repeat (300) @(posedge clock);
        cmp_per(e0, extra);
        // Mid-run reset with a nonzero divisor must bring it back to zero
        arst_n <= 1'b0;
        repeat (2) @(posedge clock);
        arst_n <= 1'b1;
        apb(1'b0, A_DIV, 32'h0, 1'b0, ex(8'h00));
        apb(1'b0, 12'h004, 32'h0, 1'b0, 33'h000000001);
        apb(1'b0, A_DIV + 12'h001, 32'h0, 1'b0, 33'h000000001);
        repeat (4) @(posedge clock);
        print_verdict();
    end
endmodule : tb_usart_baud_rate_generator
`default_nettype wire
